// file: logic/dac_output_fifo_sequencer.sv
// paced two-channel analog-output sequencer fed by packed host word writes
// assumes all inputs synchronous to clk; host is the bus initiator, this block the target
`timescale 1ns/100ps
module dac_output_fifo_sequencer
  import dac_seq_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH_BASE,
  parameter int unsigned CW    = $clog2(DEPTH) + 1
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  host_wr,
  input  wire logic [WORD_W-1:0]     host_wdata,
  output logic                       host_wr_ready,
  input  wire logic                  fifo_reset,
  input  wire logic                  trig,
  input  wire logic                  wave_mode,
  input  wire logic                  two_dac,
  input  wire logic                  first_dac,
  input  wire logic                  ext_pace_sel,
  input  wire logic                  ext_pace,
  input  wire logic [PACE_DIV_W-1:0] pace_div,
  input  wire logic                  stop_orderly,
  input  wire logic                  stop_abrupt,
  input  wire logic [PACE_DIV_W-1:0] sample_limit,
  input  wire logic                  underflow_clr,
  output logic      [SAMPLE_W-1:0]   dac0_code,
  output logic      [SAMPLE_W-1:0]   dac1_code,
  output logic                       dac0_load,
  output logic                       dac1_load,
  output logic      [CW-1:0]         fifo_count,
  output logic                       underflow,
  output logic                       running,
  output logic                       pace_out_n
);

  // samples consumed per tick: one per listed converter
  function automatic logic [1:0] need_of(input logic two);
    need_of = two ? 2'd2 : 2'd1;
  endfunction : need_of

  // ****************************************
  // host word intake
  // ****************************************
  logic                accept;
  logic                push;
  logic [SAMPLE_W-1:0] push_data;
  logic                odd_pend_r;
  logic [SAMPLE_W-1:0] odd_r;
  logic                ready_nxt;
  logic [CW-1:0]       pat_len;
  logic [SAMPLE_W-1:0] pop_data;
  logic                pop;
  logic                retx;

  // even half goes in now, odd half one cycle later
  assign accept    = host_wr & host_wr_ready;
  assign push      = accept | odd_pend_r;
  assign push_data = odd_pend_r ? odd_r : host_wdata[EVEN_LSB +: SAMPLE_W];
  // headroom of four covers both halves of a word still in flight
  assign ready_nxt = ~accept & ~fifo_reset & (fifo_count <= CW'(DEPTH - 4));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      odd_pend_r    <= 1'b0;
      odd_r         <= '0;
      host_wr_ready <= 1'b0;
    end else begin
      odd_pend_r    <= accept;
      host_wr_ready <= ready_nxt;
      if (accept) begin
        odd_r <= host_wdata[ODD_LSB +: SAMPLE_W];
      end
    end
  end

  sample_fifo #(
    .DEPTH (DEPTH),
    .W     (SAMPLE_W),
    .CW    (CW)
  ) u_store (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (fifo_reset),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .retx      (retx),
    .pop_data  (pop_data),
    .count     (fifo_count),
    .pat_len   (pat_len)
  );

  // ****************************************
  // pacing clock
  // ****************************************
  logic [TB_CNT_W-1:0]   tb_cnt_r;
  logic                  tb_en;
  logic [PACE_DIV_W-1:0] div_eff;
  logic [PACE_DIV_W-1:0] div_cnt_r;
  logic                  pace_lvl;
  logic                  pace_prev_r;
  logic                  pace_tick;

  // clamp keeps the pacer within the converter rate
  assign tb_en     = (tb_cnt_r == TB_CNT_W'(TB_DIV - 1));
  assign div_eff   = (pace_div < PACE_DIV_W'(MIN_DIV)) ? PACE_DIV_W'(MIN_DIV) : pace_div;
  assign pace_lvl  = ext_pace_sel ? ext_pace : pace_out_n;
  assign pace_tick = pace_prev_r & ~pace_lvl;

  // time base enable and active-low divider output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_cnt_r    <= '0;
      div_cnt_r   <= '0;
      pace_out_n  <= 1'b1;
      pace_prev_r <= 1'b1;
    end else begin
      tb_cnt_r    <= tb_en ? '0 : tb_cnt_r + 1'b1;
      pace_prev_r <= pace_lvl;
      if (tb_en) begin
        div_cnt_r  <= (div_cnt_r == '0) ? div_eff - 1'b1 : div_cnt_r - 1'b1;
        pace_out_n <= (div_cnt_r != '0);
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  seq_state_t            state_r;
  seq_state_t            state_nxt;
  logic [SAMPLE_W-1:0]   s0_r;
  logic [PACE_DIV_W-1:0] done_r;
  logic                  orderly_r;
  logic                  starved_r;
  logic                  avail;
  logic                  can_replay;
  logic                  limit_hit;
  logic                  active;
  logic [SAMPLE_W-1:0]   e1_data;

  assign avail      = (fifo_count >= CW'(need_of(two_dac)));
  assign can_replay = wave_mode & (pat_len >= CW'(WAVE_MIN_LEN))
                    & (pat_len >= CW'(need_of(two_dac)));
  assign limit_hit  = orderly_r & (done_r >= sample_limit);
  assign active     = (state_r != ST_IDLE) & (state_r != ST_STOPPED);
  assign pop        = (state_r == ST_FETCH0) | ((state_r == ST_FETCH1) & two_dac);
  assign retx       = (state_r == ST_RETX);
  assign e1_data    = pop_data;

  // next state; the store reset re-arms, an abrupt stop wins over any fetch
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:    if (stop_abrupt | stop_orderly) begin
                    state_nxt = ST_STOPPED;
                  end else if (trig) begin
                    state_nxt = ST_RUN;
                  end
      ST_RUN:     if (limit_hit) begin
                    state_nxt = ST_STOPPED;
                  end else if (pace_tick & avail) begin
                    state_nxt = ST_FETCH0;
                  end else if (pace_tick & can_replay) begin
                    state_nxt = ST_RETX;
                  end
      ST_RETX:    state_nxt = ST_FETCH0;
      ST_FETCH0:  state_nxt = ST_FETCH1;
      ST_FETCH1:  state_nxt = ST_LOAD;
      ST_LOAD:    state_nxt = ST_RUN;
      ST_STOPPED: state_nxt = ST_STOPPED;
      default:    state_nxt = ST_IDLE;
    endcase
    if (active & stop_abrupt) begin
      state_nxt = ST_STOPPED;
    end
    if (fifo_reset) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      running <= 1'b0;
    end else begin
      state_r <= state_nxt;
      running <= (state_nxt != ST_IDLE) & (state_nxt != ST_STOPPED);
    end
  end

  // stop bookkeeping: samples done since trigger and the orderly request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r    <= '0;
      orderly_r <= 1'b0;
    end else if (fifo_reset | (state_r == ST_IDLE)) begin
      done_r    <= '0;
      orderly_r <= 1'b0;
    end else begin
      if (stop_orderly) begin
        orderly_r <= 1'b1;
      end
      if (state_r == ST_LOAD) begin
        done_r <= done_r + PACE_DIV_W'(need_of(two_dac));
      end
    end
  end

  // ****************************************
  // converter outputs
  // ****************************************
  // entry 0 is the first listed converter, entry 1 the other one;
  // codes pass untouched since both ends use offset binary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s0_r      <= '0;
      dac0_code <= DAC_RST;
      dac1_code <= DAC_RST;
      dac0_load <= 1'b0;
      dac1_load <= 1'b0;
    end else begin
      dac0_load <= 1'b0;
      dac1_load <= 1'b0;
      if (state_r == ST_FETCH1) begin
        s0_r <= pop_data;
      end
      if ((state_r == ST_LOAD) & ~stop_abrupt & ~fifo_reset) begin
        if (first_dac) begin
          dac1_code <= s0_r;
          dac1_load <= 1'b1;
        end else begin
          dac0_code <= s0_r;
          dac0_load <= 1'b1;
        end
        if (two_dac) begin
          if (first_dac) begin
            dac0_code <= e1_data;
            dac0_load <= 1'b1;
          end else begin
            dac1_code <= e1_data;
            dac1_load <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // underflow detection
  // ****************************************
  logic starve_evt;

  // a replaying pattern empties by design, so only a store that cannot replay starves (continuous mode or a pattern under two samples)
  assign starve_evt = (state_r == ST_RUN) & pace_tick & ~avail & ~can_replay & ~limit_hit;

  // set wins over the host clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      starved_r <= 1'b0;
      underflow <= 1'b0;
    end else begin
      if (fifo_reset | push) begin
        starved_r <= 1'b0;
      end else if (starve_evt) begin
        starved_r <= 1'b1;
      end
      if (push & starved_r) begin
        underflow <= 1'b1;
      end else if (underflow_clr) begin
        underflow <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] gap_r;  // cycles since last internal pacing edge, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 8'hFF;
    end else begin
      gap_r <= (pace_tick & ~ext_pace_sel) ? 8'h01 : ((gap_r == 8'hFF) ? gap_r : gap_r + 1'b1);
    end
  end

  a_underflow_sticky : assert property (underflow & ~underflow_clr |=> underflow)
    else $error("underflow dropped without clear");
  a_underflow_cause : assert property ($rose(underflow) |-> $past(starved_r) & $past(push))
    else $error("underflow set without starved write");
  a_load_together : assert property ((dac0_load | dac1_load) & $past(two_dac)
                                     |-> dac0_load & dac1_load)
    else $error("two listed converters not updated together");
  a_hold_starved : assert property (starved_r ##1 starved_r
                                    |-> $stable(dac0_code) & $stable(dac1_code))
    else $error("outputs moved while starved");
  a_tick_fetch : assert property ((state_r == ST_RUN) & pace_tick & avail & ~limit_hit
                                  & ~stop_abrupt & ~fifo_reset
                                  |=> (state_r == ST_FETCH0) ##2 (state_r == ST_LOAD))
    else $error("pacing edge did not start a conversion");
  a_replay_empty : assert property ((state_r == ST_RUN) & pace_tick & ~avail & can_replay
                                    & ~limit_hit & ~stop_abrupt & ~fifo_reset
                                    |=> retx ##1 pop)
    else $error("empty pattern store not replayed");
  a_stop_holds : assert property ((state_r == ST_STOPPED) & ~fifo_reset
                                  |=> (state_r == ST_STOPPED) & ~running)
    else $error("trigger honoured after stop");
  a_pace_spacing : assert property (pace_tick & ~ext_pace_sel & ~$past(ext_pace_sel)
                                    |-> gap_r >= 8'(MIN_DIV * TB_DIV))
    else $error("internal pacing faster than limit");
  a_even_first : assert property (accept |=> push & (push_data == $past(host_wdata[31:16])))
    else $error("odd half not pushed after even half");

  c_paced_load : cover property (trig ##[1:300] dac0_load);
  c_two_dac    : cover property (dac0_load & dac1_load);
  c_underflow  : cover property ($rose(underflow));
  c_stop       : cover property ($rose(state_r == ST_STOPPED));

endmodule : dac_output_fifo_sequencer

// file: logic/dac_seq_pkg.sv
// constants shared by the paced analog-output sequencer and its sample store
// assumes a single 40 MHz system clock and 16-bit offset-binary samples
package dac_seq_pkg;

  // ****************************************
  // clocking and pacing
  // ****************************************
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TB_HZ       = 20_000_000;  // pacer time base
  localparam int unsigned TB_DIV      = CLK_HZ / TB_HZ;
  localparam int unsigned MAX_RATE_HZ = 500_000;     // small-step limit
  localparam int unsigned FS_RATE_HZ  = 200_000;     // full-scale-step limit
  localparam int unsigned MIN_DIV     = TB_HZ / MAX_RATE_HZ;
  localparam int unsigned FS_DIV      = TB_HZ / FS_RATE_HZ;
  localparam int unsigned PACE_DIV_W  = 24;
  localparam int unsigned TB_CNT_W    = 2;

  // ****************************************
  // sample store and data format
  // ****************************************
  localparam int unsigned FIFO_DEPTH_BASE = 4096;
  localparam int unsigned FIFO_DEPTH_EXT  = 32768;
  localparam int unsigned SAMPLE_W        = 16;
  localparam int unsigned WORD_W          = 32;
  localparam int unsigned EVEN_LSB        = 0;
  localparam int unsigned ODD_LSB         = 16;
  localparam int unsigned WAVE_MIN_LEN    = 2;
  localparam logic [15:0] DAC_RST         = 16'h8000;  // mid scale, 0 V

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_RETX, ST_FETCH0, ST_FETCH1, ST_LOAD, ST_STOPPED
  } seq_state_t;

endpackage : dac_seq_pkg

// file: logic/sample_fifo.sv
// sample store with occupancy count and pattern replay
// assumes push and pop are never asked beyond full or empty by the sequencer
`timescale 1ns/100ps
module sample_fifo
  import dac_seq_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH_BASE,
  parameter int unsigned W     = SAMPLE_W,
  parameter int unsigned CW    = $clog2(DEPTH) + 1
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clr,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  input  wire logic          retx,
  output logic      [W-1:0]  pop_data,
  output logic      [CW-1:0] count,
  output logic      [CW-1:0] pat_len
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;

  // storage and registered read port
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= push_data;
    end
    pop_data <= mem[rd_ptr_r];
  end

  // pointers, occupancy and pattern length; replay rewinds to the first sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count    <= '0;
      pat_len  <= '0;
    end else if (clr) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count    <= '0;
      pat_len  <= '0;
    end else if (retx) begin
      rd_ptr_r <= '0;
      count    <= pat_len;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
        pat_len  <= pat_len + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  a_count_clear : assert property (@(posedge clk) disable iff (!rst_n) clr |=> count == '0)
    else $error("occupancy not cleared by store reset");
  a_count_bound : assert property (@(posedge clk) disable iff (!rst_n) count <= CW'(DEPTH))
    else $error("occupancy beyond depth");
  c_replay : cover property (@(posedge clk) disable iff (!rst_n) retx ##1 count > '0);

endmodule : sample_fifo

// file: testbench/host_word_writer.sv
// host-side model: writes packed even/odd sample words into the sequencer
// assumes requests change on the falling edge and ready is sampled on the rising edge
`timescale 1ns/100ps
module host_word_writer
  import dac_seq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              host_wr_ready,
  output logic                   host_wr,
  output logic      [WORD_W-1:0] host_wdata,
  output logic                   host_err
);
  // ****************************************
  // word transfers
  // ****************************************
  initial begin
    host_wr    = 1'b0;
    host_wdata = '0;
    host_err   = 1'b0;
  end

  // one word per take; request held until ready is seen high
  task automatic send(input logic [15:0] base, input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      host_wr    = 1'b1;
      host_wdata = {base + 16'(2 * i + 1), base + 16'(2 * i)};
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (host_wr_ready !== 1'b1 && w < 50);
      if (w >= 50) host_err = 1'b1;
      @(negedge clk);
      host_wr    = 1'b0;
      host_wdata = ~host_wdata;  // released bus must not look like a word
    end
  endtask : send
endmodule : host_word_writer

// file: testbench/dac_output_fifo_sequencer_tb.sv
// self-checking bench for the paced analog-output sequencer
// assumes one 40 MHz clock; the host model supplies every word write
`timescale 1ns/100ps
module dac_output_fifo_sequencer_tb;
  import dac_seq_pkg::*;
  localparam int unsigned DEPTH = 64;  // small store keeps the run short
  localparam int unsigned CW    = $clog2(DEPTH) + 1;
  localparam int          LIMIT = 20000;

  logic                  clk, rst_n, host_wr, host_wr_ready, host_err, fifo_reset, trig;
  logic                  wave_mode, two_dac, first_dac, ext_pace_sel, ext_pace;
  logic                  stop_orderly, stop_abrupt, underflow_clr, dac0_load, dac1_load;
  logic                  underflow, running, pace_out_n;
  logic [WORD_W-1:0]     host_wdata;
  logic [PACE_DIV_W-1:0] pace_div, sample_limit;
  logic [SAMPLE_W-1:0]   dac0_code, dac1_code;
  logic [CW-1:0]         fifo_count;
  logic [1:0]            load_mask;
  int                    num_errors, n_checks, n_loads, cyc;

  // ****************************************
  // clock, parts and monitors
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dac_output_fifo_sequencer #(.DEPTH(DEPTH), .CW(CW)) u_dut (
    .clk(clk), .rst_n(rst_n), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_wr_ready(host_wr_ready), .fifo_reset(fifo_reset), .trig(trig),
    .wave_mode(wave_mode), .two_dac(two_dac), .first_dac(first_dac),
    .ext_pace_sel(ext_pace_sel), .ext_pace(ext_pace), .pace_div(pace_div),
    .stop_orderly(stop_orderly), .stop_abrupt(stop_abrupt), .sample_limit(sample_limit),
    .underflow_clr(underflow_clr), .dac0_code(dac0_code), .dac1_code(dac1_code),
    .dac0_load(dac0_load), .dac1_load(dac1_load), .fifo_count(fifo_count),
    .underflow(underflow), .running(running), .pace_out_n(pace_out_n)
  );

  host_word_writer u_host (
    .clk(clk), .host_wr_ready(host_wr_ready), .host_wr(host_wr),
    .host_wdata(host_wdata), .host_err(host_err)
  );

  // count loads and cycles; a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (dac0_load === 1'b1 || dac1_load === 1'b1) begin
      n_loads++;
      load_mask = {dac1_load, dac0_load};
    end
    if (cyc == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // bounded wait for exactly one converter update
  task automatic wait_load(input int lim);
    int start;
    start = n_loads;
    for (int i = 0; i < lim && n_loads == start; i++) @(negedge clk);
    check(16'(n_loads - start), 16'd1, "load count");
  endtask : wait_load

  task automatic pulse_ctl(input int which);
    @(negedge clk);
    case (which)
      0: fifo_reset = 1'b1;
      1: trig = 1'b1;
      2: stop_abrupt = 1'b1;
      default: underflow_clr = 1'b1;
    endcase
    @(negedge clk);
    {fifo_reset, trig, stop_abrupt, underflow_clr} = 4'h0;
  endtask : pulse_ctl

  // one falling edge on the external pacer, expecting a dac1 update
  task automatic ext_tick(input logic [15:0] exp);
    ext_pace = 1'b0;
    wait_load(12);
    ext_pace = 1'b1;
    check(dac1_code, exp, "dac1 code");
    check(16'(load_mask), 16'h2, "load mask");
    repeat (6) @(negedge clk);
  endtask : ext_tick

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check(dac0_code, 16'h8000, "dac0 rest");
    check(16'(fifo_count), 16'h0, "count rest");
    check(16'({underflow, running}), 16'h0, "flags rest");
    $display("test reset done");
  endtask : t_reset

  task automatic t_count();
    pulse_ctl(0);
    u_host.send(16'h0100, 3);
    repeat (3) @(negedge clk);
    check(16'(fifo_count), 16'd6, "count after loads");
    pulse_ctl(0);
    repeat (2) @(negedge clk);
    check(16'(fifo_count), 16'h0, "count after clear");
    $display("test count done");
  endtask : t_count

  task automatic t_pace();
    int k;
    bit hi;
    k = 0;
    hi = 0;
    for (int i = 0; i < 200 && pace_out_n !== 1'b0; i++) @(negedge clk);
    while (k < 200) begin
      @(negedge clk);
      k++;
      if (pace_out_n === 1'b1) hi = 1;
      else if (hi) break;
    end
    check(16'(k), 16'd80, "pacer period");
    $display("test pace done");
  endtask : t_pace

  task automatic t_two_dac();
    int snap;
    two_dac = 1'b1;
    u_host.send(16'h1000, 2);
    pulse_ctl(1);
    check(16'(running), 16'h1, "running");
    wait_load(100);
    check(dac0_code, 16'h1000, "entry0 first");
    check(dac1_code, 16'h1001, "entry1 first");
    check(16'(load_mask), 16'h3, "both load");
    wait_load(100);
    check(dac1_code, 16'h1003, "entry1 second");
    snap = n_loads;
    repeat (100) @(negedge clk);
    check(16'(n_loads - snap), 16'h0, "starved tick");
    check(dac0_code, 16'h1002, "held code");
    check(16'(underflow), 16'h0, "no flag yet");
    u_host.send(16'h2000, 1);
    repeat (3) @(negedge clk);
    check(16'(underflow), 16'h1, "underflow set");
    wait_load(100);
    check(dac1_code, 16'h2001, "late data");
    repeat (100) @(negedge clk);
    check(16'(underflow), 16'h1, "sticky");
    pulse_ctl(3);
    check(16'(underflow), 16'h0, "cleared");
    $display("test two_dac done");
  endtask : t_two_dac

  task automatic t_wave();
    int snap;
    {wave_mode, two_dac, first_dac, ext_pace_sel} = 4'b1011;
    pulse_ctl(0);
    u_host.send(16'hA000, 1);  // whole two-sample pattern first
    pulse_ctl(1);
    ext_tick(16'hA000);
    ext_tick(16'hA001);
    ext_tick(16'hA000);
    ext_tick(16'hA001);
    pulse_ctl(2);
    repeat (3) @(negedge clk);
    check(16'(running), 16'h0, "abrupt stop");
    pulse_ctl(1);
    repeat (3) @(negedge clk);
    check(16'(running), 16'h0, "trig ignored");
    snap = n_loads;
    ext_pace = 1'b0;
    repeat (12) @(negedge clk);
    check(16'(n_loads - snap), 16'h0, "no output");
    check(16'(host_err), 16'h0, "host writes taken");
    $display("test wave done");
  endtask : t_wave

  // orderly stop on the internal pacer after two single-converter updates
  task automatic t_orderly();
    int snap;
    {wave_mode, two_dac, first_dac, ext_pace_sel} = 4'b0000;
    sample_limit = 24'h000002;
    pulse_ctl(0);
    u_host.send(16'h3000, 2);
    pulse_ctl(1);
    stop_orderly = 1'b1;
    @(negedge clk);
    stop_orderly = 1'b0;
    wait_load(100);
    check(dac0_code, 16'h3000, "orderly first");
    wait_load(100);
    check(dac0_code, 16'h3001, "orderly second");
    snap = n_loads;
    repeat (200) @(negedge clk);
    check(16'(n_loads - snap), 16'h0, "no load after limit");
    check(16'(running), 16'h0, "orderly stop");
    check(16'(fifo_count), 16'd2, "samples kept");
    $display("test orderly done");
  endtask : t_orderly

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_n, fifo_reset, trig, wave_mode, two_dac, first_dac} = 6'h0;
    {ext_pace_sel, stop_orderly, stop_abrupt, underflow_clr} = 4'h0;
    ext_pace     = 1'b1;
    pace_div     = 24'h000028;
    sample_limit = 24'h0003E8;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_count();
    t_pace();
    t_two_dac();
    pulse_ctl(0);
    t_wave();
    t_orderly();
    complete_run();
  end
endmodule : dac_output_fifo_sequencer_tb
